// >>> hdl/sbc_pkg.sv
// constants, command codes, register map and states of the bank command engine
// assumes a 100 MHz clock and a controller that keeps the command timing

package sbc_pkg;

	// --------------------------------------------------------------
	// command pins {cs_n, ras_n, cas_n, we_n}
	// --------------------------------------------------------------
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_READ = 4'h5;
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_BST = 4'h6;

	// --------------------------------------------------------------
	// address layout
	// --------------------------------------------------------------
	localparam int ADDR_W = 10;
	localparam int COL_W = 8;
	localparam int ROW_W = 9;
	localparam int ALL_BANKS_BIT = 8;
	localparam int AUTO_PRE_BIT = 8;
	localparam int BANK_BIT = 9;
	localparam int BANKS = 2;
	localparam int BYTES = 2;
	localparam int READ_MASK_DLY = 2;

	// --------------------------------------------------------------
	// mode codes
	// --------------------------------------------------------------
	localparam logic [2:0] BL_ONE = 3'h0;
	localparam logic [2:0] BL_TWO = 3'h1;
	localparam logic [2:0] BL_FOUR = 3'h2;
	localparam logic [2:0] BL_EIGHT = 3'h3;
	localparam logic [2:0] BL_FULL = 3'h7;
	localparam logic [2:0] CL_ONE = 3'h1;
	localparam logic [2:0] CL_TWO = 3'h2;

	// --------------------------------------------------------------
	// register map
	// --------------------------------------------------------------
	localparam int REG_AW = 4;
	localparam logic [3:0] REG_MODE = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam int MODE_BL_LSB = 0;
	localparam int MODE_CL_LSB = 4;
	localparam int MODE_FLD_W = 3;
	localparam logic [2:0] MODE_BL_RST = 3'h0;
	localparam logic [2:0] MODE_CL_RST = 3'h2;
	localparam int ST_OPEN_LSB = 0;
	localparam int ST_PRE_LSB = 2;
	localparam int ST_STATE_LSB = 4;

	// --------------------------------------------------------------
	// timing
	// --------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int TRP_NS = 20;
	localparam int TRAS_NS = 50;
	localparam int TRP_CYC = (TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TRAS_CYC = (TRAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 8;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_READ = 2'b01,
		ST_WRITE = 2'b10
	} sbc_state_t;

endpackage

// >>> hdl/sbc_bank_engine.sv
// command decode, bank state, burst engine and data path of the two-bank memory
// assumes commands and data synchronous to clk; dq pins resolved outside
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps

module sbc_bank_engine
#(
	parameter int ROW_W = sbc_pkg::ROW_W
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [sbc_pkg::ADDR_W-1:0] addr,
	input wire logic low_byte_mask,
	input wire logic high_byte_mask,
	input wire logic [15:0] dq_in,
	output logic [15:0] dq_out,
	output logic [1:0] dq_oe,
	input wire logic [sbc_pkg::REG_AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata
);

	localparam int COL_W = sbc_pkg::COL_W;
	localparam int AW = 1 + ROW_W + COL_W;
	localparam int DEPTH = 2 ** AW;

	// ----------------------------------------------------------------
	// command decode and mode
	// ----------------------------------------------------------------
	logic [3:0] cmd;
	logic act_cmd, rd_cmd, wr_cmd, pre_cmd, bst_cmd;
	logic cmd_bank;
	logic [2:0] bl_code;
	logic [2:0] cl;
	logic full_page;
	logic [COL_W-1:0] burst_mask;
	logic [1:0] byte_mask;

	assign cmd = {cs_n, ras_n, cas_n, we_n};
	assign act_cmd = (cmd == sbc_pkg::CMD_ACT);
	assign rd_cmd = (cmd == sbc_pkg::CMD_READ);
	assign wr_cmd = (cmd == sbc_pkg::CMD_WRITE);
	assign pre_cmd = (cmd == sbc_pkg::CMD_PRE);
	assign bst_cmd = (cmd == sbc_pkg::CMD_BST);
	assign cmd_bank = addr[sbc_pkg::BANK_BIT];
	assign byte_mask = {high_byte_mask, low_byte_mask};
	assign full_page = (bl_code == sbc_pkg::BL_FULL);

	always_comb
	begin
		case (bl_code)
			sbc_pkg::BL_TWO: burst_mask = 8'h01;
			sbc_pkg::BL_FOUR: burst_mask = 8'h03;
			sbc_pkg::BL_EIGHT: burst_mask = 8'h07;
			sbc_pkg::BL_FULL: burst_mask = 8'hFF;
			default: burst_mask = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// bank state
	// ----------------------------------------------------------------
	logic [1:0] bank_open, act_ok, pre_ok, pre_req, pre_hit, ap_fire, precharging;
	logic [ROW_W-1:0] open_row [sbc_pkg::BANKS];

	for (genvar g = 0; g < sbc_pkg::BANKS; g++)
	begin : bank_blk
		logic open;
		logic [ROW_W-1:0] row;
		logic [sbc_pkg::CNT_W-1:0] trp_cnt;
		logic [sbc_pkg::CNT_W-1:0] tras_cnt;

		// line eight widens a precharge to both banks
		assign pre_req[g] = pre_cmd && pre_ok[g]
			&& (addr[sbc_pkg::ALL_BANKS_BIT] || cmd_bank == 1'(g));
		assign pre_hit[g] = pre_req[g] || ap_fire[g];
		assign act_ok[g] = !open && trp_cnt == '0;
		assign pre_ok[g] = (tras_cnt == '0);
		assign bank_open[g] = open;
		assign precharging[g] = (trp_cnt != '0);
		assign open_row[g] = row;

		always_ff @(posedge clk or posedge reset)
		begin
			if (reset)
			begin
				open <= 1'b0;
				row <= '0;
				trp_cnt <= '0;
				tras_cnt <= '0;
			end
			else
			begin
				if (trp_cnt != '0)
					trp_cnt <= trp_cnt - 8'h01;
				if (tras_cnt != '0)
					tras_cnt <= tras_cnt - 8'h01;
				if (pre_hit[g] && open)
				begin
					open <= 1'b0;
					trp_cnt <= 8'(sbc_pkg::TRP_CYC);
				end
				else if (act_cmd && cmd_bank == 1'(g) && act_ok[g])
				begin
					open <= 1'b1;
					row <= addr[ROW_W-1:0];
					tras_cnt <= 8'(sbc_pkg::TRAS_CYC);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// burst engine
	// ----------------------------------------------------------------
	sbc_pkg::sbc_state_t state;
	logic eng_bank, eng_ap;
	logic [COL_W-1:0] eng_col, eng_left;
	logic rd_go, wr_go, kill;
	logic issue_valid, issue_write, issue_bank, issue_ap, issue_last;
	logic [COL_W-1:0] issue_col, col_inc, next_col;
	logic [ROW_W-1:0] issue_row;

	assign rd_go = rd_cmd && bank_open[cmd_bank];
	assign wr_go = wr_cmd && bank_open[cmd_bank];
	// burst stop or a precharge on the busy bank ends the burst now
	assign kill = bst_cmd || pre_req[eng_bank];
	assign issue_row = open_row[issue_bank];
	assign col_inc = COL_W'(issue_col + 8'h01);
	assign next_col = (issue_col & ~burst_mask) | (col_inc & burst_mask);

	always_comb
	begin
		issue_valid = 1'b0;
		issue_write = 1'b0;
		issue_bank = eng_bank;
		issue_col = eng_col;
		issue_ap = eng_ap;
		issue_last = 1'b0;
		if (rd_go || wr_go)
		begin
			issue_valid = 1'b1;
			issue_write = wr_go;
			issue_bank = cmd_bank;
			issue_col = addr[COL_W-1:0];
			issue_ap = addr[sbc_pkg::AUTO_PRE_BIT] && !full_page;
			issue_last = !full_page && burst_mask == '0;
		end
		else if (state != sbc_pkg::ST_IDLE && !kill)
		begin
			issue_valid = 1'b1;
			issue_write = (state == sbc_pkg::ST_WRITE);
			issue_last = !full_page && eng_left == 8'h01;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state <= sbc_pkg::ST_IDLE;
			eng_bank <= 1'b0;
			eng_ap <= 1'b0;
			eng_col <= '0;
			eng_left <= '0;
			ap_fire <= '0;
		end
		else
		begin
			ap_fire <= '0;
			if (issue_valid)
			begin
				eng_bank <= issue_bank;
				eng_col <= next_col;
				eng_ap <= issue_ap;
				if (issue_last)
				begin
					state <= sbc_pkg::ST_IDLE;
					if (issue_ap)
						ap_fire[issue_bank] <= 1'b1;
				end
				else
				begin
					state <= issue_write ? sbc_pkg::ST_WRITE : sbc_pkg::ST_READ;
					eng_left <= (rd_go || wr_go) ? burst_mask : eng_left - 8'h01;
				end
			end
			else
				state <= sbc_pkg::ST_IDLE;
		end
	end

	// ----------------------------------------------------------------
	// read valid pipeline, output window, read mask delay
	// ----------------------------------------------------------------
	logic rd_issue, vs1, vs2, dv, pre_win, drive_win;
	logic [1:0] mq [sbc_pkg::READ_MASK_DLY];
	logic [1:0] byte_we;
	logic [AW-1:0] mem_idx;

	assign rd_issue = issue_valid && !issue_write;
	assign mem_idx = {issue_bank, issue_row, issue_col};

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			vs1 <= 1'b0;
			vs2 <= 1'b0;
			dv <= 1'b0;
		end
		else
		begin
			vs1 <= rd_issue;
			vs2 <= vs1;
			case (cl)
				sbc_pkg::CL_ONE: dv <= rd_issue;
				sbc_pkg::CL_TWO: dv <= vs1;
				default: dv <= vs2;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			for (int i = 0; i < sbc_pkg::READ_MASK_DLY; i++)
				mq[i] <= '0;
		else
		begin
			mq[0] <= byte_mask;
			for (int i = 1; i < sbc_pkg::READ_MASK_DLY; i++)
				mq[i] <= mq[i-1];
		end
	end

	always_comb
	begin
		case (cl)
			sbc_pkg::CL_ONE: pre_win = rd_issue;
			sbc_pkg::CL_TWO: pre_win = vs1;
			default: pre_win = vs2;
		endcase
	end

	// drivers on a cycle ahead of the word, off when no word follows
	assign drive_win = dv || pre_win;

	// ----------------------------------------------------------------
	// storage, one array per byte lane
	// ----------------------------------------------------------------
	for (genvar b = 0; b < sbc_pkg::BYTES; b++)
	begin : lane_blk
		logic [7:0] mem [DEPTH];
		logic [7:0] s1, s2, q;

		assign byte_we[b] = issue_valid && issue_write && !byte_mask[b];
		assign dq_out[b*8 +: 8] = q;
		assign dq_oe[b] = drive_win && !mq[sbc_pkg::READ_MASK_DLY-1][b];

		always_ff @(posedge clk)
		begin
			if (byte_we[b])
				mem[mem_idx] <= dq_in[b*8 +: 8];
		end

		always_ff @(posedge clk or posedge reset)
		begin
			if (reset)
			begin
				s1 <= '0;
				s2 <= '0;
				q <= '0;
			end
			else
			begin
				s1 <= mem[mem_idx];
				s2 <= s1;
				case (cl)
					sbc_pkg::CL_ONE: q <= mem[mem_idx];
					sbc_pkg::CL_TWO: q <= s1;
					default: q <= s2;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	logic [31:0] rd_word;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			bl_code <= sbc_pkg::MODE_BL_RST;
			cl <= sbc_pkg::MODE_CL_RST;
		end
		else if (reg_write && reg_addr == sbc_pkg::REG_MODE)
		begin
			bl_code <= reg_wdata[sbc_pkg::MODE_BL_LSB +: sbc_pkg::MODE_FLD_W];
			cl <= reg_wdata[sbc_pkg::MODE_CL_LSB +: sbc_pkg::MODE_FLD_W];
		end
	end

	always_comb
	begin
		rd_word = '0;
		case (reg_addr)
			sbc_pkg::REG_MODE:
			begin
				rd_word[sbc_pkg::MODE_BL_LSB +: sbc_pkg::MODE_FLD_W] = bl_code;
				rd_word[sbc_pkg::MODE_CL_LSB +: sbc_pkg::MODE_FLD_W] = cl;
			end
			sbc_pkg::REG_STATUS:
			begin
				rd_word[sbc_pkg::ST_OPEN_LSB +: 2] = bank_open;
				rd_word[sbc_pkg::ST_PRE_LSB +: 2] = precharging;
				rd_word[sbc_pkg::ST_STATE_LSB +: 2] = state;
			end
			default: rd_word = '0;
		endcase
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			reg_rdata <= '0;
		else
			reg_rdata <= reg_read ? rd_word : '0;
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_act_bank_sel: assert property (@(posedge clk) disable iff (reset)
		(act_cmd && !cmd_bank && act_ok[0])
		|=> bank_open[0] && open_row[0] == $past(addr[ROW_W-1:0]))
		else $error("activate did not open bank zero with its row");

	a_pre_both: assert property (@(posedge clk) disable iff (reset)
		(pre_cmd && addr[sbc_pkg::ALL_BANKS_BIT] && pre_ok == 2'b11) |=> bank_open == 2'b00)
		else $error("precharge all left a bank open");

	a_rd_latency: assert property (@(posedge clk) disable iff (reset)
		(rd_go && cl == sbc_pkg::CL_TWO) |=> vs1 ##1 dv)
		else $error("read data not at latency two");

	a_oe_early: assert property (@(posedge clk) disable iff (reset)
		(rd_go && cl == 3'h3 && !low_byte_mask && !$past(low_byte_mask)) |-> ##2 dq_oe[0])
		else $error("drivers not on one cycle before data");

	a_rd_mask: assert property (@(posedge clk) disable iff (reset)
		high_byte_mask |-> ##2 !dq_oe[1])
		else $error("high byte not floated two clocks after mask");

	a_wr_mask: assert property (@(posedge clk) disable iff (reset)
		(wr_go && low_byte_mask) |-> !byte_we[0] && byte_we[1] == !high_byte_mask)
		else $error("write mask not applied in command cycle");

	a_rd_auto_pre: assert property (@(posedge clk) disable iff (reset)
		(rd_issue && issue_last && issue_ap && !issue_bank) |-> ##2 !bank_open[0])
		else $error("read auto-precharge did not close bank");

	a_full_no_ap: assert property (@(posedge clk) disable iff (reset)
		(full_page && issue_valid) |-> !issue_last ##1 ap_fire == 2'b00)
		else $error("full page burst ended or auto-precharged");

	a_pre_rd_end: assert property (@(posedge clk) disable iff (reset)
		(state == sbc_pkg::ST_READ && pre_req[eng_bank] && cl == sbc_pkg::CL_TWO)
		|-> ##2 !dv)
		else $error("read output not ended by precharge");

	a_pre_wr_stop: assert property (@(posedge clk) disable iff (reset)
		(state == sbc_pkg::ST_WRITE && pre_req[eng_bank] && !rd_cmd && !wr_cmd)
		|-> byte_we == 2'b00 ##1 state == sbc_pkg::ST_IDLE)
		else $error("write continued after same-bank precharge");

endmodule

// >>> test/sbc_ctrl_model.sv
// controller model: commands, addresses, byte masks and write data
// assumes the bench calls its tasks one after another; cmd and nop take one clock, wr one per word plus one
`timescale 1ns/1ps

module sbc_ctrl_model
(
	input wire logic clk,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [sbc_pkg::ADDR_W-1:0] addr,
	output logic low_byte_mask,
	output logic high_byte_mask,
	output logic [15:0] dq_in
);
	initial
	begin
		{cs_n, ras_n, cas_n, we_n} = 4'hF;
		addr = 10'h000;
		{high_byte_mask, low_byte_mask} = 2'h0;
		dq_in = 16'h0000;
	end

	// one clock of command, address, masks and data
	task automatic cmd(input logic [3:0] c, input logic [9:0] a, input logic [1:0] m,
		input logic [15:0] d);
		@(posedge clk);
		{cs_n, ras_n, cas_n, we_n} <= c;
		addr <= a;
		{high_byte_mask, low_byte_mask} <= m;
		dq_in <= d;
	endtask

	// deselected: address and data lines show the inverse of the last value
	task automatic nop();
		cmd(4'hF, ~addr, 2'h0, ~dq_in);
	endtask

	// burst write to an open bank, then one clock of recovery
	task automatic wr(input logic [9:0] a, input logic [15:0] d[$], input logic [1:0] m);
		cmd(sbc_pkg::CMD_WRITE, a, m, d[0]);
		for (int i = 1; i < d.size(); i++)
			cmd(4'hF, ~addr, m, d[i]);
		nop();
	endtask
endmodule

// >>> test/sdram_bank_command_engine_tb.sv
// self-checking bench for the two-bank command engine
// assumes the controller model drives all command and data inputs
`timescale 1ns/1ps

module sdram_bank_command_engine_tb;
	typedef struct {logic [2:0] bl; int n; logic [2:0] cl; logic [7:0] col;} sbc_row_t;
	logic clk, reset, cs_n, ras_n, cas_n, we_n, low_byte_mask, high_byte_mask;
	logic reg_write, reg_read;
	logic [9:0] addr;
	logic [15:0] dq_in, dq_out;
	logic [1:0] dq_oe;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, st;
	logic [7:0] b;
	logic [15:0] wd[$], ex[$];
	int errors, comparisons;
	sbc_row_t rows[4] = '{'{sbc_pkg::BL_ONE, 1, sbc_pkg::CL_ONE, 8'h03},
		'{sbc_pkg::BL_TWO, 2, sbc_pkg::CL_TWO, 8'h15},
		'{sbc_pkg::BL_FOUR, 4, 3'h3, 8'h26},
		'{sbc_pkg::BL_EIGHT, 8, sbc_pkg::CL_TWO, 8'h3D}};

	sbc_bank_engine #(.ROW_W(2)) u_sbc_bank_engine
	(
		.clk(clk), .reset(reset), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.addr(addr), .low_byte_mask(low_byte_mask), .high_byte_mask(high_byte_mask),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata)
	);

	sbc_ctrl_model u_sbc_ctrl_model
	(
		.clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr),
		.low_byte_mask(low_byte_mask), .high_byte_mask(high_byte_mask), .dq_in(dq_in)
	);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic nop(input int k);
		repeat (k) u_sbc_ctrl_model.nop();
	endtask

	task automatic cmd(input logic [3:0] k, input logic [9:0] a, input logic [1:0] m);
		u_sbc_ctrl_model.cmd(k, a, m, ~dq_in);
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		nop(1);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'h1;
		nop(1);
		reg_write <= 1'h0;
	endtask

	task automatic reg_rd(input logic [3:0] a);
		nop(1);
		reg_addr <= a;
		reg_read <= 1'h1;
		nop(1);
		reg_read <= 1'h0;
		@(negedge clk);
		st = reg_rdata;
	endtask

	// read burst: drivers, data words and release against ex
	task automatic rd_chk(input logic [9:0] a, input int cl);
		cmd(sbc_pkg::CMD_READ, a, 2'h0);
		for (int j = 0; j <= cl + ex.size(); j++)
		begin
			@(negedge clk);
			check(dq_oe, (j >= cl - 1 && j < cl + ex.size()) ? 2'h3 : 2'h0);
			if (j >= cl && j < cl + ex.size())
				check(dq_out, ex[j - cl]);
			nop(1);
		end
	endtask

	// ------------------------------------------------------------
	// clock, watchdog, sequence
	// ------------------------------------------------------------
	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	initial
	begin
		repeat (5000) @(posedge clk);
		errors++;
		tally_and_finish();
	end

	initial
	begin
		reset = 1'h1;
		reg_write = 1'h0;
		reg_read = 1'h0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		errors = 0;
		comparisons = 0;
		repeat (5) @(posedge clk);
		reset <= 1'h0;
		reg_rd(4'h0);
		check(st, 32'h20);
		reg_rd(4'h8);
		check(st, 32'h0);
		reg_wr(4'h4, 32'hFFFF);
		reg_rd(4'h4);
		check(st, 32'h0);
		cmd(sbc_pkg::CMD_ACT, 10'h000, 2'h0);
		for (int r = 0; r < 4; r++)
		begin
			reg_wr(4'h0, {25'h0, rows[r].cl, 1'h0, rows[r].bl});
			b = rows[r].col & ~8'(rows[r].n - 1);
			wd.delete();
			ex.delete();
			for (int k = 0; k < rows[r].n; k++)
			begin
				wd.push_back({4'(r), 4'hA, b + 8'(k)});
				ex.push_back({4'(r), 4'hA, b | ((rows[r].col + 8'(k)) & 8'(rows[r].n - 1))});
			end
			u_sbc_ctrl_model.wr({2'h0, b}, wd, 2'h0);
			rd_chk({2'h0, rows[r].col}, int'(rows[r].cl));
		end
		// read mask, then a read cut short by a second read
		reg_wr(4'h0, 32'h22);
		cmd(sbc_pkg::CMD_READ, 10'h024, 2'h0);
		cmd(4'hF, 10'h000, 2'h1);
		nop(2);
		@(negedge clk);
		check(dq_oe, 2'h2);
		check(dq_out[15:8], 8'h2A);
		nop(1);
		@(negedge clk);
		check(dq_oe, 2'h3);
		nop(3);
		cmd(sbc_pkg::CMD_READ, 10'h024, 2'h0);
		cmd(sbc_pkg::CMD_READ, 10'h03D, 2'h0);
		nop(1);
		@(negedge clk);
		check(dq_out, 16'h2A24);
		nop(1);
		@(negedge clk);
		check(dq_out, 16'h3A3D);
		nop(6);
		// write with the high byte masked
		reg_wr(4'h0, 32'h20);
		wd = {16'hFFFF};
		u_sbc_ctrl_model.wr(10'h003, wd, 2'h2);
		ex = {16'h0AFF};
		rd_chk(10'h003, 2);
		// precharge of both banks cuts a read short
		reg_wr(4'h0, 32'h23);
		cmd(sbc_pkg::CMD_READ, 10'h038, 2'h0);
		nop(1);
		cmd(sbc_pkg::CMD_PRE, 10'h300, 2'h0);
		nop(1);
		@(negedge clk);
		check(dq_out, 16'h3A39);
		nop(1);
		@(negedge clk);
		check(dq_oe, 2'h0);
		nop(3);
		reg_rd(4'h4);
		check(st, 32'h0);
		// write with auto-precharge on bank one
		cmd(sbc_pkg::CMD_ACT, 10'h200, 2'h0);
		reg_wr(4'h0, 32'h21);
		wd = {16'h1111, 16'h2222};
		u_sbc_ctrl_model.wr(10'h310, wd, 2'h0);
		reg_rd(4'h4);
		check(st & 32'hF, 32'h8);
		// early precharge refused, auto-precharge ignored in full page
		nop(3);
		cmd(sbc_pkg::CMD_ACT, 10'h200, 2'h0);
		cmd(sbc_pkg::CMD_PRE, 10'h200, 2'h0);
		reg_wr(4'h0, 32'h27);
		wd = {16'h5555};
		u_sbc_ctrl_model.wr(10'h300, wd, 2'h0);
		cmd(sbc_pkg::CMD_BST, 10'h000, 2'h0);
		nop(1);
		reg_rd(4'h4);
		check(st & 32'h3, 32'h2);
		// write cut by a write, other-bank precharge, then same-bank precharge
		reg_wr(4'h0, 32'h22);
		cmd(sbc_pkg::CMD_ACT, 10'h000, 2'h0);
		nop(2);
		u_sbc_ctrl_model.cmd(sbc_pkg::CMD_WRITE, 10'h024, 2'h0, 16'h4040);
		u_sbc_ctrl_model.cmd(sbc_pkg::CMD_WRITE, 10'h03C, 2'h0, 16'h5050);
		u_sbc_ctrl_model.cmd(4'hF, 10'h000, 2'h0, 16'h5151);
		u_sbc_ctrl_model.cmd(sbc_pkg::CMD_PRE, 10'h200, 2'h0, 16'h5252);
		u_sbc_ctrl_model.cmd(sbc_pkg::CMD_PRE, 10'h000, 2'h3, 16'h5353);
		nop(2);
		cmd(sbc_pkg::CMD_ACT, 10'h000, 2'h0);
		ex = {16'h5050, 16'h5151, 16'h5252, 16'h3A3F};
		rd_chk(10'h03C, 2);
		// masked read cut by a write, then a read cutting that write
		cmd(4'hF, 10'h000, 2'h3);
		cmd(sbc_pkg::CMD_READ, 10'h024, 2'h3);
		u_sbc_ctrl_model.cmd(sbc_pkg::CMD_WRITE, 10'h03C, 2'h0, 16'h6060);
		@(negedge clk);
		check(dq_oe, 2'h0);
		u_sbc_ctrl_model.cmd(4'hF, 10'h000, 2'h0, 16'h6161);
		@(negedge clk);
		check(dq_oe, 2'h0);
		ex = {16'h6060, 16'h6161, 16'h5252, 16'h3A3F};
		rd_chk(10'h03C, 2);
		// read with auto-precharge closes bank zero
		ex = {16'h4040, 16'h2A25, 16'h2A26, 16'h2A27};
		rd_chk(10'h124, 2);
		reg_rd(4'h4);
		check(st & 32'h3, 32'h0);
		tally_and_finish();
	end
endmodule
